// File: ipas_pkg.sv
// Purpose: shared constants and types for the interrupt acceptance and entry sequencer
// Assumes: 32-bit AXI4-Lite register bus, one 50 MHz clock, synchronous active-low reset
// Notes: every offset, the flag and source field positions and the flag and level reset values used by the design files are named here
package ipas_pkg;

	// sizes
	localparam int NUM_SRC = 8;
	localparam int SRC_W = 3;
	localparam int LVL_W = 3;
	localparam int FLG_W = 8;
	localparam int TMP_W = LVL_W + FLG_W;
	localparam int PC_W = 20;
	localparam int NUM_W = 6;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;

	// priority levels: 000 is level 0 (never taken), 111 is level 7
	localparam logic [LVL_W-1:0] LVL_OFF = 3'h0;
	localparam logic [LVL_W-1:0] LVL_RST = 3'h0;

	// flag register bit positions and reset value
	localparam int FLG_I = 0;
	localparam int FLG_D = 1;
	localparam int FLG_U = 2;
	localparam logic [FLG_W-1:0] FLG_RST = 8'h00;

	// source control word: level in the low bits, request bit above it
	localparam int SRC_REQ_BIT = 3;
	localparam int SRC_CTL_W = 4;

	// software interrupt numbers that keep the stack select flag
	localparam logic [NUM_W-1:0] SW_KEEP_LO = 6'h20;
	localparam logic [NUM_W-1:0] SW_KEEP_HI = 6'h3f;
	// interrupt number of source 0; later sources follow in order
	localparam logic [NUM_W-1:0] SRC_NUM_BASE = 6'h08;

	// register map (byte addresses)
	localparam logic [ADDR_W-1:0] OFF_FLAG = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_LEVEL = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_ALIGN = 8'h03;
	localparam int SRC_PAGE_LO = 5;
	localparam int SRC_IDX_LO = 2;
	localparam logic [ADDR_W-SRC_PAGE_LO-1:0] SRC_PAGE = 3'h1;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// entry sequence states, one-hot
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_FETCH = 8'h02,
		ST_SAVE = 8'h04,
		ST_CLRF = 8'h08,
		ST_PUSHF = 8'h10,
		ST_PUSHPC = 8'h20,
		ST_SETLVL = 8'h40,
		ST_RESUME = 8'h80
	} ipas_state_t;

endpackage : ipas_pkg

// File: ipas_src_slot.sv
// Purpose: one peripheral source: its level select field, its request bit and its eligibility
// Assumes: setReq is a one-cycle pulse from the peripheral; wrEn comes from the bus decoder
// Notes: software can only clear the request bit; a write of one to it is dropped
`timescale 1ns/1ns
module ipas_src_slot
	import ipas_pkg::*;
(
	input wire logic clk, // bus clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic wrEn, // software write of the control word
	input wire logic [SRC_CTL_W-1:0] wrData, // {request, level}
	input wire logic setReq, // peripheral asks for service
	input wire logic clrReq, // entry sequence took this source
	input wire logic [LVL_W-1:0] processor_priority_level, // processor priority level
	input wire logic iFlag, // global enable flag
	output logic [LVL_W-1:0] level, // programmed level
	output logic req, // request bit
	output logic eligible // may be accepted now
);

	typedef struct packed {
		logic [LVL_W-1:0] lvl;
		logic req;
	} ipas_slot_t;

	ipas_slot_t s_q;
	ipas_slot_t s_d;

	// request set wins over any clear in the same cycle, so a request is never lost
	always_comb begin
		s_d = s_q;
		if (wrEn) begin
			s_d.lvl = wrData[LVL_W-1:0];
		end
		if (setReq) begin
			s_d.req = 1'b1;
		end else if (clrReq || (wrEn && !wrData[SRC_REQ_BIT])) begin
			s_d.req = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q.lvl <= LVL_RST;
			s_q.req <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign level = s_q.lvl;
	assign req = s_q.req;
	// level 0 never qualifies; ipl 7 blocks all because no level exceeds it
	assign eligible = iFlag && s_q.req && (s_q.lvl != LVL_OFF) && (s_q.lvl > processor_priority_level);

endmodule : ipas_src_slot

// File: ipas_pick.sv
// Purpose: choose the eligible source with the highest level
// Assumes: eligibility already folds in enable, request and level compare
// Notes: on equal levels the lowest index wins, a fixed tie order
`timescale 1ns/1ns
module ipas_pick
	import ipas_pkg::*;
(
	input wire logic [NUM_SRC-1:0] elig, // per-source eligibility
	input wire logic [NUM_SRC-1:0][LVL_W-1:0] lvl, // per-source level
	output logic hit, // some source is eligible
	output logic [SRC_W-1:0] winIdx, // winning source
	output logic [LVL_W-1:0] winLvl // its level
);

	// strict compare keeps the earlier index on a tie
	always_comb begin
		hit = 1'b0;
		winIdx = '0;
		winLvl = LVL_OFF;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (elig[i] && (!hit || lvl[i] > winLvl)) begin
				hit = 1'b1;
				winIdx = SRC_W'(i);
				winLvl = lvl[i];
			end
		end
	end

endmodule : ipas_pick

// File: ipas_accept_seq.sv
// Purpose: maskable interrupt acceptance and the fixed entry sequence of the CPU
// Assumes: instrDone pulses as an instruction completes; strInstr is high during a string or
//          multiply-accumulate instruction that may be cut short; pcIn is valid when accepting
// Notes: registers sit on AXI4-Lite; the temporary flag copy has no address at all
`timescale 1ns/1ns
module ipas_accept_seq
	import ipas_pkg::*;
(
	input wire logic clk, // 50 MHz bus clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [DATA_W-1:0] s_axi_wdata, // write data
	input wire logic [STRB_W-1:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [DATA_W-1:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [NUM_SRC-1:0] srcReq, // peripheral request pulses
	input wire logic instrDone, // current instruction completes
	input wire logic strInstr, // suspendable instruction in progress
	input wire logic swReq, // software interrupt instruction
	input wire logic [NUM_W-1:0] swNum, // its interrupt number
	input wire logic [PC_W-1:0] pcIn, // program counter to save
	output logic infoRd, // read of address zero for number and level
	output logic [NUM_W-1:0] intNum, // accepted interrupt number
	output logic [LVL_W-1:0] intLvl, // accepted interrupt level
	output logic suspendStrb, // running instruction is cut short
	output logic pushValid, // stack write this cycle
	output logic [PC_W-1:0] pushData, // stack word
	output logic resumeStrb, // fetch from handler start now
	output logic [LVL_W-1:0] procLevel, // processor priority level
	output logic [FLG_W-1:0] flagsOut // flag register
);

	typedef struct packed {
		ipas_state_t st;
		logic [FLG_W-1:0] flag_register;
		logic [LVL_W-1:0] processor_priority_level;
		logic [TMP_W-1:0] tmp;
		logic [SRC_W-1:0] accIdx;
		logic [LVL_W-1:0] accLvl;
		logic accSw;
		logic [NUM_W-1:0] accNum;
		logic [PC_W-1:0] accPc;
		logic infoRd;
		logic suspend;
		logic pushValid;
		logic [PC_W-1:0] pushData;
		logic resume;
		logic awHave;
		logic [ADDR_W-1:0] awAddr;
		logic wHave;
		logic [FLG_W-1:0] wData;
		logic wLow;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} ipas_main_t;

	ipas_main_t s_q;
	ipas_main_t s_d;

	logic [NUM_SRC-1:0] slotWr;
	logic [NUM_SRC-1:0] clrReq;
	logic [NUM_SRC-1:0] slotReq;
	logic [NUM_SRC-1:0] slotElig;
	logic [NUM_SRC-1:0][LVL_W-1:0] slotLvl;
	logic winHit;
	logic [SRC_W-1:0] winIdx;
	logic [LVL_W-1:0] winLvl;
	logic [SRC_W-1:0] rdIdx;
	logic [SRC_W-1:0] wrIdx;
	logic keepU;

	// each source keeps its own request and level, apart from the flags and processor level
	for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
		ipas_src_slot u_slot (
			.clk(clk),
			.rstn(rstn),
			.wrEn(slotWr[i]),
			.wrData(s_q.wData[SRC_CTL_W-1:0]),
			.setReq(srcReq[i]),
			.clrReq(clrReq[i]),
			.processor_priority_level(s_q.processor_priority_level),
			.iFlag(s_q.flag_register[FLG_I]),
			.level(slotLvl[i]),
			.req(slotReq[i]),
			.eligible(slotElig[i])
		);
	end

	ipas_pick u_pick (
		.elig(slotElig),
		.lvl(slotLvl),
		.hit(winHit),
		.winIdx(winIdx),
		.winLvl(winLvl)
	);

	assign rdIdx = s_axi_araddr[SRC_IDX_LO +: SRC_W];
	assign wrIdx = s_q.awAddr[SRC_IDX_LO +: SRC_W];
	assign keepU = s_q.accSw && (s_q.accNum >= SW_KEEP_LO) && (s_q.accNum <= SW_KEEP_HI);

	// bus slave first, then the sequencer; a hardware step overrides a software write
	// to the same flag in the same cycle, since the sequence must leave flags known
	always_comb begin
		s_d = s_q;
		slotWr = '0;
		clrReq = '0;
		s_d.infoRd = 1'b0;
		s_d.suspend = 1'b0;
		s_d.pushValid = 1'b0;
		s_d.resume = 1'b0;

		// write address and data are taken independently, in either order
		if (s_axi_awvalid && s_q.awready) begin
			s_d.awHave = 1'b1;
			s_d.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wready) begin
			s_d.wHave = 1'b1;
			s_d.wData = s_axi_wdata[FLG_W-1:0];
			s_d.wLow = s_axi_wstrb[0];
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		// all writable fields live in byte 0, so only that lane matters
		if (s_q.awHave && s_q.wHave && !s_q.bvalid) begin
			s_d.awHave = 1'b0;
			s_d.wHave = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = RESP_OKAY;
			if ((s_q.awAddr & ADDR_ALIGN) != '0) begin
				s_d.bresp = RESP_SLVERR;
			end else if (s_q.awAddr == OFF_FLAG) begin
				if (s_q.wLow) begin
					s_d.flag_register = s_q.wData;
				end
			end else if (s_q.awAddr == OFF_LEVEL) begin
				if (s_q.wLow) begin
					s_d.processor_priority_level = s_q.wData[LVL_W-1:0];
				end
			end else if (s_q.awAddr == OFF_STAT) begin
				s_d.bresp = RESP_OKAY; // status is read only, write ignored
			end else if (s_q.awAddr[ADDR_W-1:SRC_PAGE_LO] == SRC_PAGE) begin
				slotWr[wrIdx] = s_q.wLow;
			end else begin
				s_d.bresp = RESP_SLVERR;
			end
		end
		s_d.awready = !s_d.awHave;
		s_d.wready = !s_d.wHave;

		// read: one outstanding; the temporary flag copy has no address
		if (s_axi_arvalid && s_q.arready) begin
			s_d.arready = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rresp = RESP_OKAY;
			s_d.rdata = '0;
			if ((s_axi_araddr & ADDR_ALIGN) != '0) begin
				s_d.rresp = RESP_SLVERR;
			end else if (s_axi_araddr == OFF_FLAG) begin
				s_d.rdata = DATA_W'(s_q.flag_register);
			end else if (s_axi_araddr == OFF_LEVEL) begin
				s_d.rdata = DATA_W'(s_q.processor_priority_level);
			end else if (s_axi_araddr == OFF_STAT) begin
				// busy, software entry, number, spare, level
				s_d.rdata = DATA_W'({s_q.st != ST_IDLE, s_q.accSw, s_q.accNum, 1'b0, s_q.accLvl});
			end else if (s_axi_araddr[ADDR_W-1:SRC_PAGE_LO] == SRC_PAGE) begin
				s_d.rdata = DATA_W'({slotReq[rdIdx], slotLvl[rdIdx]});
			end else begin
				s_d.rresp = RESP_SLVERR;
			end
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
			s_d.arready = 1'b1;
		end

		// entry sequence
		unique case (s_q.st)
			ST_IDLE: begin
				if (swReq) begin
					// software interrupts ignore enable and level
					s_d.accSw = 1'b1;
					s_d.accNum = swNum;
					s_d.accLvl = s_q.processor_priority_level;
					s_d.accPc = pcIn;
					s_d.infoRd = 1'b1;
					s_d.st = ST_FETCH;
				end else if (winHit && (instrDone || strInstr)) begin
					s_d.accSw = 1'b0;
					s_d.accIdx = winIdx;
					s_d.accLvl = winLvl;
					s_d.accNum = SRC_NUM_BASE + NUM_W'(winIdx);
					s_d.accPc = pcIn;
					s_d.suspend = strInstr && !instrDone;
					s_d.infoRd = 1'b1;
					s_d.st = ST_FETCH;
				end
			end
			ST_FETCH: begin
				clrReq[s_q.accIdx] = !s_q.accSw;
				s_d.st = ST_SAVE;
			end
			ST_SAVE: begin
				// internal copy only, never mapped on the bus
				s_d.tmp = {s_q.processor_priority_level, s_q.flag_register};
				s_d.st = ST_CLRF;
			end
			ST_CLRF: begin
				s_d.flag_register[FLG_I] = 1'b0;
				s_d.flag_register[FLG_D] = 1'b0;
				if (!keepU) begin
					s_d.flag_register[FLG_U] = 1'b0;
				end
				s_d.pushValid = 1'b1;
				s_d.pushData = {{(PC_W-TMP_W){1'b0}}, s_q.tmp};
				s_d.st = ST_PUSHF;
			end
			ST_PUSHF: begin
				s_d.pushValid = 1'b1;
				s_d.pushData = s_q.accPc;
				s_d.st = ST_PUSHPC;
			end
			ST_PUSHPC: begin
				s_d.st = ST_SETLVL;
			end
			ST_SETLVL: begin
				if (!s_q.accSw) begin
					s_d.processor_priority_level = s_q.accLvl;
				end
				s_d.resume = 1'b1;
				s_d.st = ST_RESUME;
			end
			ST_RESUME: begin
				s_d.st = ST_IDLE;
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
	end

	// reset clears the global enable so nothing maskable is taken early
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= '0;
			// the read channel must be open after reset, nothing else ever raises it first
			s_q.arready <= 1'b1;
			s_q.st <= ST_IDLE;
			s_q.flag_register <= FLG_RST;
			s_q.processor_priority_level <= LVL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rvalid = s_q.rvalid;
	assign infoRd = s_q.infoRd;
	assign intNum = s_q.accNum;
	assign intLvl = s_q.accLvl;
	assign suspendStrb = s_q.suspend;
	assign pushValid = s_q.pushValid;
	assign pushData = s_q.pushData;
	assign resumeStrb = s_q.resume;
	assign procLevel = s_q.processor_priority_level;
	assign flagsOut = s_q.flag_register;

	// helper views for the checks below
	logic iNow;
	logic uNow;
	logic [LVL_W-1:0] iplNow;
	logic [PC_W-1:0] tmpWord;
	assign iNow = s_q.flag_register[FLG_I];
	assign uNow = s_q.flag_register[FLG_U];
	assign iplNow = s_q.processor_priority_level;
	assign tmpWord = {{(PC_W-TMP_W){1'b0}}, s_q.tmp};

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	chk_fetch_after_done: assert property (
		s_q.st == ST_IDLE && instrDone && winHit && !swReq |=> s_q.st == ST_FETCH && s_q.infoRd)
		else $error("entry did not start after instruction end");
	chk_level_above_ipl: assert property (
		s_q.st == ST_FETCH && !s_q.accSw |-> s_q.accLvl > $past(iplNow))
		else $error("accepted level not above processor level");
	chk_level_zero_never: assert property (
		s_q.st == ST_FETCH && !s_q.accSw |-> s_q.accLvl != LVL_OFF)
		else $error("level zero source accepted");
	chk_enable_needed: assert property (
		s_q.st == ST_FETCH && !s_q.accSw |-> $past(iNow))
		else $error("maskable accepted with enable clear");
	chk_req_cleared: assert property (
		s_q.st == ST_FETCH && !s_q.accSw && !srcReq[s_q.accIdx] |=> !slotReq[s_q.accIdx])
		else $error("request bit not cleared on entry");
	chk_flags_cleared: assert property (
		s_q.st == ST_CLRF |=> !iNow && !s_q.flag_register[FLG_D] && (keepU ? uNow == $past(uNow) : !uNow))
		else $error("flags wrong after clear step");
	chk_push_order: assert property (
		s_q.st == ST_PUSHF |-> s_q.pushValid && s_q.pushData == tmpWord
			##1 s_q.pushValid && s_q.pushData == s_q.accPc ##1 !s_q.pushValid)
		else $error("stack pushes out of order");
	chk_ipl_loaded: assert property (
		s_q.st == ST_SETLVL && !s_q.accSw |=> s_q.processor_priority_level == $past(s_q.accLvl))
		else $error("processor level not loaded");
	chk_resume_end: assert property (
		s_q.st == ST_FETCH |-> ##6 s_q.resume ##1 s_q.st == ST_IDLE)
		else $error("handler start not reached in time");
	chk_suspend_mid: assert property (
		s_q.st == ST_IDLE && strInstr && !instrDone && winHit && !swReq |=> s_q.suspend)
		else $error("suspendable instruction not cut short");

	cov_maskable: cover property (s_q.st == ST_FETCH && !s_q.accSw);
	cov_software: cover property (s_q.st == ST_CLRF && keepU);
	cov_suspend: cover property (s_q.suspend);

endmodule : ipas_accept_seq

// File: ipas_cpu_model.sv
// Purpose: stand-in for the peripheral sources and the instruction sequencer
// Assumes: the bench calls the tasks; every change lands by non-blocking assignment at a rising edge
// Notes: strobes last one cycle; stack words are logged in arrival order
`timescale 1ns/1ns
module ipas_cpu_model
	import ipas_pkg::*;
(
	input wire logic clk, // bus clock
	output logic [NUM_SRC-1:0] srcReq, // request pulses
	output logic instrDone, // instruction completes
	output logic strInstr, // suspendable instruction running
	output logic swReq, // software interrupt
	output logic [NUM_W-1:0] swNum, // its number
	output logic [PC_W-1:0] pcIn, // pc to save
	input wire logic pushValid, // stack write
	input wire logic [PC_W-1:0] pushData // stack word
);
	logic [PC_W-1:0] pushQ[$];

	// idle at time zero; the pc is a fixed marker so a swapped push order shows
	initial begin
		srcReq = '0;
		instrDone = 1'b0;
		strInstr = 1'b0;
		swReq = 1'b0;
		swNum = '0;
		pcIn = 20'h5_a3c1;
	end

	// log every stack word
	always @(posedge clk) begin
		if (pushValid) begin
			pushQ.push_back(pushData);
		end
	end

	// a source asks for service with a one-cycle pulse, only hardware sets the bit
	task automatic fire(input int i);
		@(posedge clk);
		srcReq <= NUM_SRC'(1) << i;
		@(posedge clk);
		srcReq <= '0;
	endtask : fire

	// the running instruction ends
	task automatic done();
		@(posedge clk);
		instrDone <= 1'b1;
		@(posedge clk);
		instrDone <= 1'b0;
	endtask : done

	// a software interrupt instruction executes
	task automatic sw(input logic [NUM_W-1:0] n);
		@(posedge clk);
		swReq <= 1'b1;
		swNum <= n;
		@(posedge clk);
		swReq <= 1'b0;
	endtask : sw

	// a string or multiply-accumulate instruction starts or stops
	task automatic setStr(input logic v);
		@(posedge clk);
		strInstr <= v;
	endtask : setStr
endmodule : ipas_cpu_model

// File: ipas_accept_seq_bench.sv
// Purpose: self-checking bench for acceptance and the entry sequence
// Assumes: register access over AXI4-Lite; the peripherals and the cpu side come from ipas_cpu_model
// Notes: a hung read costs a bounded wait and a mismatch, the run goes on
`timescale 1ns/1ns
module ipas_accept_seq_bench
	import ipas_pkg::*;
;
	typedef struct packed {
		logic [LVL_W-1:0] lvl;
		logic [LVL_W-1:0] processor_priority_level;
		logic en;
		logic acc;
	} ipas_row_t;
	localparam logic [ADDR_W-1:0] SRC0 = 8'h20;
	localparam ipas_row_t ROWS [8] = '{'{3'h1, 3'h0, 1'b1, 1'b1}, '{3'h7, 3'h6, 1'b1, 1'b1},
		'{3'h3, 3'h3, 1'b1, 1'b0}, '{3'h2, 3'h3, 1'b1, 1'b0}, '{3'h0, 3'h0, 1'b1, 1'b0},
		'{3'h7, 3'h7, 1'b1, 1'b0}, '{3'h5, 3'h2, 1'b0, 1'b0}, '{3'h4, 3'h3, 1'b1, 1'b1}};

	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, instrDone, strInstr, swReq;
	logic infoRd, suspendStrb, pushValid, resumeStrb, sawSusp;
	logic [1:0] bresp, rresp, resp;
	logic [DATA_W-1:0] rdata, rd;
	logic [NUM_SRC-1:0] srcReq;
	logic [NUM_W-1:0] swNum, intNum;
	logic [PC_W-1:0] pcIn, pushData;
	logic [LVL_W-1:0] intLvl, procLevel;
	logic [FLG_W-1:0] flagsOut, f;
	ipas_row_t r;
	int failures = 0;
	int total_checks = 0;
	int cyc = 0;
	int infoAt, resAt;

	ipas_accept_seq ipas_accept_seq_i (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .srcReq(srcReq),
		.instrDone(instrDone), .strInstr(strInstr), .swReq(swReq), .swNum(swNum), .pcIn(pcIn),
		.infoRd(infoRd), .intNum(intNum), .intLvl(intLvl), .suspendStrb(suspendStrb), .pushValid(pushValid),
		.pushData(pushData), .resumeStrb(resumeStrb), .procLevel(procLevel), .flagsOut(flagsOut));
	ipas_cpu_model ipas_cpu_model_i (.clk(clk), .srcReq(srcReq), .instrDone(instrDone), .strInstr(strInstr),
		.swReq(swReq), .swNum(swNum), .pcIn(pcIn), .pushValid(pushValid), .pushData(pushData));

	// 50 MHz clock
	initial begin
		forever #10 clk = ~clk;
	end

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			results();
		end
	end

	task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// write: address and data offered together, each released once taken
	task automatic axw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 60);
		resp = bresp;
		bready <= 1'b0;
		chk("bvalid", bvalid, 1'b1);
	endtask : axw

	task automatic axr(input logic [ADDR_W-1:0] a);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 60);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
		arvalid <= 1'b0;
		chk("rvalid", rvalid, 1'b1);
	endtask : axr

	// record in which cycle the one-cycle strobes show, sampled once settled
	task automatic watch(input int n);
		infoAt = -1;
		resAt = -1;
		sawSusp = 1'b0;
		for (int k = 0; k < n; k++) begin
			#1;
			if (infoRd === 1'b1 && infoAt < 0) infoAt = k;
			if (resumeStrb === 1'b1 && resAt < 0) resAt = k;
			if (suspendStrb === 1'b1) sawSusp = 1'b1;
			@(posedge clk);
		end
	endtask : watch

	task automatic results();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results

	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		#1;
		chk("level after reset", procLevel, 3'h0);
		chk("flags after reset", flagsOut, 8'h00);
		// one row per acceptance case; the control word is set while disabled and cleared after a row that is not accepted
		for (int i = 0; i < 8; i++) begin
			r = ROWS[i];
			f = {5'h00, 2'b11, r.en};
			axw(OFF_FLAG, '0);
			axw(SRC0, {29'h0, r.lvl});
			axw(OFF_LEVEL, {29'h0, r.processor_priority_level});
			ipas_cpu_model_i.fire(0);
			repeat (2) @(posedge clk);
			axw(OFF_FLAG, {24'h0, f});
			chk("write resp", resp, RESP_OKAY);
			chk("level kept", procLevel, r.processor_priority_level);
			chk("flags kept", flagsOut, f);
			watch(3);
			chk("early entry", infoAt, -1);
			ipas_cpu_model_i.pushQ.delete();
			ipas_cpu_model_i.done();
			watch(12);
			chk("entry start", infoAt, r.acc ? 0 : -1);
			if (r.acc) begin
				chk("number", intNum, SRC_NUM_BASE);
				chk("info level", intLvl, r.lvl);
				chk("resume", resAt, 6);
				chk("new level", procLevel, r.lvl);
				chk("flags cleared", flagsOut, 8'h00);
				chk("pushes", ipas_cpu_model_i.pushQ.size(), 2);
				chk("flag push", ipas_cpu_model_i.pushQ[0], {9'h000, r.processor_priority_level, f});
				chk("pc push", ipas_cpu_model_i.pushQ[1], pcIn);
				axr(SRC0);
				chk("request cleared", rd, {29'h0, r.lvl});
			end else begin
				chk("no pushes", ipas_cpu_model_i.pushQ.size(), 0);
				axw(SRC0, '0);
			end
		end
		// software entries: numbers 32..63 keep the stack select flag, the level stays
		foreach (ROWS[k]) begin
			if (k < 2) begin
				axw(OFF_LEVEL, 32'h0000_0003);
				axw(OFF_FLAG, 32'h0000_0007);
				ipas_cpu_model_i.sw(k == 0 ? 6'h25 : 6'h10);
				watch(10);
				chk("sw number", intNum, k == 0 ? 6'h25 : 6'h10);
				chk("sw flags", flagsOut, k == 0 ? 8'h04 : 8'h00);
				chk("sw level", procLevel, 3'h3);
			end
		end
		// a suspendable instruction gives way without completing
		axw(OFF_FLAG, '0);
		axw(SRC0, 32'h0000_0005);
		axw(OFF_LEVEL, '0);
		axw(OFF_FLAG, 32'h0000_0001);
		ipas_cpu_model_i.setStr(1'b1);
		ipas_cpu_model_i.fire(0);
		watch(12);
		chk("suspend entry", infoAt, 1);
		chk("suspend strobe", sawSusp, 1'b1);
		ipas_cpu_model_i.setStr(1'b0);
		// software writing a one to the request bit has no effect
		axw(OFF_FLAG, '0);
		axw(OFF_LEVEL, '0);
		axw(SRC0, 32'h0000_000b);
		axr(SRC0);
		chk("request not set", rd, 32'h0000_0003);
		axw(OFF_FLAG, 32'h0000_0001);
		ipas_cpu_model_i.done();
		watch(4);
		chk("no entry", infoAt, -1);
		// the temporary flag copy has no address: a write there is refused and changes nothing
		axw(8'h0c, 32'h0000_0007);
		chk("hidden write resp", resp, RESP_SLVERR);
		chk("flags untouched", flagsOut, 8'h01);
		axr(8'h0c);
		chk("hidden resp", resp, RESP_SLVERR);
		chk("hidden data", rd, '0);
		results();
	end
endmodule : ipas_accept_seq_bench
